/* File: pkg/pulse_gen_consts.svh */
`ifndef PULSE_GEN_CONSTS_SVH
`define PULSE_GEN_CONSTS_SVH
// Register offsets (byte addresses)
`define OFS_CTRL      8'h00
`define OFS_PERIOD    8'h04
`define OFS_WIDTH     8'h08
`define OFS_TSTART    8'h0c
`define OFS_TADDR     8'h10
`define OFS_TDATA     8'h14
`define OFS_CMD       8'h18
`define OFS_STATUS    8'h1c
`define OFS_IRQ_STAT  8'h20
`define OFS_IRQ_CLR   8'h24
`define OFS_IRQ_EN    8'h28
// Control byte fields
`define CB_PERIOD     0
`define CB_WIDTH      1
`define CB_MSTICK     3
`define CB_MULTI      5
`define CB_PWM        6
`define CB_ENABLE     7
// Reset values
`define RST_CTRL      8'h00
`define RST_WORD      16'h0000
// Profile table
`define TBL_BYTES     2048
`define TBL_AW        11
`define SEG_BYTES     4'h8
// Timing
`define CLK_NS        20
`define TICK_US_NS    1000
`define TICK_MS_NS    1000000
`define TICK_US_CYC   (`TICK_US_NS / `CLK_NS)
`define TICK_MS_CYC   (`TICK_MS_NS / `CLK_NS)
`endif

/* File: pkg/pulse_gen_pkg.sv */
package pulse_gen_pkg;
  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_type;
  // One profile segment
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] delta;
    logic [31:0] count;
  } seg_type;
  // Generator state, Gray along idle-fetch-run
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b11,
    ST_PWM   = 2'b10
  } gen_state_type;
endpackage : pulse_gen_pkg

/* File: rtl/pulse_gen.sv */
// Behaviour
// R1: Profile holds up to 255 segments
// R2: Each pulse period steps by segment delta
// R3: Table opens with segment count byte
// R4: Entry: period, signed delta, 32-bit count
// R5: Delta in ticks, applied every pulse
// R6: Pulse k period is initial plus delta(k-1)
// R7: Segment duration follows linear period stepping
// R8: D3/DB start PWM loading width and period
// R9: Software writes period and width first
// R10: Values adopted only on program command
// R11: D2/DA load only width, PWM kept
// R12: Software drives output low first scan
// R13: Unflagged values ignored at program command
// R14: Profile completion raises complete event
// R15: Fetch next segment, stop after last
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "pulse_gen_consts.svh"
module pulse_gen #(
  parameter int unsigned TICK_MS_CYCLES = `TICK_MS_CYC
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Register port
  input  wire pulse_gen_pkg::bus_req_type bus_req,
  output logic [31:0]                    rdata,
  // Pulse output and interrupt
  output logic                           pulse_output_pin,
  output logic                           irq
);
  import pulse_gen_pkg::*;

  // Profile table, written byte by byte through the data window
  logic [7:0]  tbl_mem [`TBL_BYTES];
  // Software registers
  logic [7:0]  ctrl_r, ctrl_nxt;              // Control byte
  logic [15:0] period_word_r, period_word_nxt; // Staged period
  logic [15:0] width_word_r, width_word_nxt;   // Staged width
  logic [`TBL_AW-1:0] tstart_r, tstart_nxt;   // Table start offset
  logic [`TBL_AW-1:0] taddr_r, taddr_nxt;     // Table write pointer
  logic        irq_stat_r, irq_stat_nxt;      // Sticky complete flag
  logic        irq_en_r, irq_en_nxt;          // Interrupt enable
  logic [31:0] rdata_r, rdata_nxt;            // Read data
  // Generator state
  gen_state_type state_r, state_nxt;
  logic        ms_r, ms_nxt;                  // Millisecond tick
  logic [15:0] per_act_r, per_act_nxt;        // Active PWM period
  logic [15:0] wid_act_r, wid_act_nxt;        // Active PWM width
  logic [15:0] cur_r, cur_nxt;                // Current pulse period
  logic [15:0] delta_r, delta_nxt;            // Signed segment delta
  logic [31:0] left_r, left_nxt;              // Pulses left in segment
  logic [7:0]  segs_r, segs_nxt;              // Segments left
  logic [7:0]  segn_r, segn_nxt;              // Segment in progress
  logic [`TBL_AW-1:0] ptr_r, ptr_nxt;         // Table read pointer
  logic [3:0]  fidx_r, fidx_nxt;              // Fetch byte index
  logic [55:0] shf_r, shf_nxt;                // Fetch assembly
  logic [15:0] pre_r, pre_nxt;                // Tick prescaler
  logic [15:0] phase_r, phase_nxt;            // Ticks into the pulse
  logic        out_r, out_nxt;                // Registered pin
  logic        done_ev;                       // Profile complete pulse
  // Decoded strobes
  logic        cmd;
  logic        tick;
  logic [7:0]  rbyte;
  seg_type     seg;

  // Tick length in clocks, minus one, per time base
  function automatic logic [15:0] tick_max(input logic ms);
    tick_max = ms ? 16'(TICK_MS_CYCLES - 1) : 16'(`TICK_US_CYC - 1);
  endfunction : tick_max

  // Byte under the read pointer; async read keeps fetch one byte a cycle
  assign rbyte = tbl_mem[ptr_r];
  assign cmd   = bus_req.wr && (bus_req.addr == `OFS_CMD);
  assign tick  = (pre_r == tick_max(ms_r));
  // Big-endian entry: period, delta, count
  assign seg   = {shf_r, rbyte}; // R4

  // Table memory write, one byte per data write
  always_ff @(posedge clock)
  begin
    if (bus_req.wr && bus_req.addr == `OFS_TDATA)
    begin
      tbl_mem[taddr_r] <= bus_req.wdata[7:0];
    end
  end

  // Register file next values
  always_comb
  begin
    ctrl_nxt        = ctrl_r;
    period_word_nxt = period_word_r;
    width_word_nxt  = width_word_r;
    tstart_nxt      = tstart_r;
    taddr_nxt       = taddr_r;
    irq_en_nxt      = irq_en_r;
    irq_stat_nxt    = irq_stat_r;
    rdata_nxt       = 32'h0000_0000;
    // Staging writes do not touch the running output
    if (bus_req.wr)
    begin
      case (bus_req.addr) // R10
        `OFS_CTRL:    ctrl_nxt        = bus_req.wdata[7:0];
        `OFS_PERIOD:  period_word_nxt = bus_req.wdata[15:0];
        `OFS_WIDTH:   width_word_nxt  = bus_req.wdata[15:0];
        `OFS_TSTART:  tstart_nxt      = bus_req.wdata[`TBL_AW-1:0];
        `OFS_TADDR:   taddr_nxt       = bus_req.wdata[`TBL_AW-1:0];
        `OFS_TDATA:   taddr_nxt       = taddr_r + 1'b1;
        `OFS_IRQ_CLR: irq_stat_nxt    = irq_stat_r & ~bus_req.wdata[0];
        `OFS_IRQ_EN:  irq_en_nxt      = bus_req.wdata[0];
        default:      ;
      endcase
    end
    // A completion in the clearing cycle still sets the flag
    if (done_ev)
    begin
      irq_stat_nxt = 1'b1; // R14
    end
    // Reads answer in the next cycle; unmapped reads return zero
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `OFS_CTRL:     rdata_nxt = {24'h00_0000, ctrl_r};
        `OFS_PERIOD:   rdata_nxt = {16'h0000, period_word_r};
        `OFS_WIDTH:    rdata_nxt = {16'h0000, width_word_r};
        `OFS_TSTART:   rdata_nxt = {21'h00_0000, tstart_r};
        `OFS_TADDR:    rdata_nxt = {21'h00_0000, taddr_r};
        `OFS_STATUS:   rdata_nxt = {16'h0000, segn_r, 6'h00, state_r == ST_PWM,
                                    state_r == ST_IDLE};
        `OFS_IRQ_STAT: rdata_nxt = {31'h0000_0000, irq_stat_r};
        `OFS_IRQ_EN:   rdata_nxt = {31'h0000_0000, irq_en_r};
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r        <= `RST_CTRL;
      period_word_r <= `RST_WORD;
      width_word_r  <= `RST_WORD;
      tstart_r      <= '0;
      taddr_r       <= '0;
      irq_stat_r    <= 1'b0;
      irq_en_r      <= 1'b0;
      rdata_r       <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r        <= ctrl_nxt;
      period_word_r <= period_word_nxt;
      width_word_r  <= width_word_nxt;
      tstart_r      <= tstart_nxt;
      taddr_r       <= taddr_nxt;
      irq_stat_r    <= irq_stat_nxt;
      irq_en_r      <= irq_en_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  // Generator next state
  always_comb
  begin
    state_nxt   = state_r;
    ms_nxt      = ms_r;
    per_act_nxt = per_act_r;
    wid_act_nxt = wid_act_r;
    cur_nxt     = cur_r;
    delta_nxt   = delta_r;
    left_nxt    = left_r;
    segs_nxt    = segs_r;
    segn_nxt    = segn_r;
    ptr_nxt     = ptr_r;
    fidx_nxt    = fidx_r;
    shf_nxt     = shf_r;
    pre_nxt     = tick ? 16'h0000 : pre_r + 16'h0001;
    phase_nxt   = phase_r;
    done_ev     = 1'b0;
    case (state_r)
      ST_FETCH:
      begin
        // Pull eight entry bytes, one per clock
        shf_nxt  = {shf_r[47:0], rbyte};
        ptr_nxt  = ptr_r + 1'b1;
        fidx_nxt = fidx_r + 4'h1;
        if (fidx_r == `SEG_BYTES - 4'h1)
        begin
          cur_nxt   = seg.period; // R4
          delta_nxt = seg.delta;
          left_nxt  = seg.count;
          phase_nxt = 16'h0000;
          pre_nxt   = 16'h0000;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (tick)
        begin
          phase_nxt = phase_r + 16'h0001;
          // Period ends; periods below two ticks end every tick
          if (phase_r + 16'h0001 >= cur_r)
          begin
            phase_nxt = 16'h0000;
            if (left_r <= 32'h0000_0001)
            begin
              // Segment spent: next entry or stop
              segs_nxt = segs_r - 8'h01; // R15
              if (segs_r == 8'h01)
              begin
                state_nxt = ST_IDLE; // R15
                done_ev   = 1'b1; // R14
              end
              else
              begin
                segn_nxt  = segn_r + 8'h01;
                fidx_nxt  = 4'h0;
                state_nxt = ST_FETCH; // R15
              end
            end
            else
            begin
              // Whole-tick step per pulse, no fractions kept
              cur_nxt  = cur_r + delta_r; // R2 R5 R6 R7
              left_nxt = left_r - 32'h0000_0001;
            end
          end
        end
      end
      ST_PWM:
      begin
        if (tick)
        begin
          phase_nxt = (phase_r + 16'h0001 >= per_act_r) ? 16'h0000
                                                         : phase_r + 16'h0001;
        end
      end
      default:
      begin
        phase_nxt = 16'h0000;
      end
    endcase
    // Program command overrides whatever runs
    if (cmd)
    begin
      ms_nxt    = ctrl_r[`CB_MSTICK]; // R8
      pre_nxt   = 16'h0000;
      phase_nxt = 16'h0000;
      if (!ctrl_r[`CB_ENABLE])
      begin
        state_nxt = ST_IDLE;
      end
      else if (ctrl_r[`CB_PWM])
      begin
        // Only flagged values are taken
        if (ctrl_r[`CB_PERIOD])
        begin
          per_act_nxt = period_word_r; // R8 R13
        end
        if (ctrl_r[`CB_WIDTH])
        begin
          wid_act_nxt = width_word_r; // R8 R11 R13
        end
        state_nxt = ST_PWM; // R11
      end
      else if (ctrl_r[`CB_MULTI])
      begin
        // Count byte first, up to 255 segments
        segs_nxt = tbl_mem[tstart_r]; // R1 R3
        segn_nxt = 8'h01;
        ptr_nxt  = tstart_r + 1'b1;
        fidx_nxt = 4'h0;
        if (tbl_mem[tstart_r] == 8'h00)
        begin
          state_nxt = ST_IDLE; // R3
          done_ev   = 1'b1;
        end
        else
        begin
          state_nxt = ST_FETCH;
        end
      end
      else
      begin
        // Single-segment trains are not provided
        state_nxt = ST_IDLE;
      end
    end
    // Half-period high in profile mode, width high in PWM
    case (state_nxt)
      ST_RUN:  out_nxt = (phase_nxt < {1'b0, cur_nxt[15:1]});
      ST_PWM:  out_nxt = (phase_nxt < wid_act_nxt);
      default: out_nxt = 1'b0;
    endcase
  end

  // Generator storage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= ST_IDLE;
      ms_r      <= 1'b0;
      per_act_r <= `RST_WORD;
      wid_act_r <= `RST_WORD;
      cur_r     <= 16'h0000;
      delta_r   <= 16'h0000;
      left_r    <= 32'h0000_0000;
      segs_r    <= 8'h00;
      segn_r    <= 8'h00;
      ptr_r     <= '0;
      fidx_r    <= 4'h0;
      shf_r     <= 56'h0;
      pre_r     <= 16'h0000;
      phase_r   <= 16'h0000;
      out_r     <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      ms_r      <= ms_nxt;
      per_act_r <= per_act_nxt;
      wid_act_r <= wid_act_nxt;
      cur_r     <= cur_nxt;
      delta_r   <= delta_nxt;
      left_r    <= left_nxt;
      segs_r    <= segs_nxt;
      segn_r    <= segn_nxt;
      ptr_r     <= ptr_nxt;
      fidx_r    <= fidx_nxt;
      shf_r     <= shf_nxt;
      pre_r     <= pre_nxt;
      phase_r   <= phase_nxt;
      out_r     <= out_nxt;
    end
  end

  assign rdata            = rdata_r;
  assign pulse_output_pin = out_r;
  assign irq              = irq_stat_r & irq_en_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_idle_pin_low: assert property ((state_r == ST_IDLE) |-> !out_r) // R15
    else $error("pin high while idle");
  a_done_flags: assert property (done_ev |=> irq_stat_r) // R14
    else $error("completion not flagged");
  a_period_step: assert property ( // R6
    (state_r == ST_RUN && tick && phase_r + 16'h0001 >= cur_r
     && left_r > 32'h1 && !cmd)
    |=> cur_r == 16'($past(cur_r) + $past(delta_r)))
    else $error("period not stepped by delta");
  a_staging_quiet: assert property ( // R10
    !cmd |=> $stable(per_act_r) && $stable(wid_act_r))
    else $error("active values changed without command");
  a_pwm_full_load: assert property ( // R8
    (cmd && (ctrl_r == 8'hd3 || ctrl_r == 8'hdb))
    |=> state_r == ST_PWM && per_act_r == $past(period_word_r)
        && wid_act_r == $past(width_word_r))
    else $error("full load not taken");
  a_width_only: assert property ( // R11
    (cmd && (ctrl_r == 8'hd2 || ctrl_r == 8'hda))
    |=> state_r == ST_PWM && $stable(per_act_r)
        && wid_act_r == $past(width_word_r))
    else $error("width-only load wrong");
  a_last_segment: assert property ( // R15
    (state_r == ST_RUN && segs_r == 8'h01 && left_r <= 32'h1 && tick
     && phase_r + 16'h0001 >= cur_r && !cmd) |=> state_r == ST_IDLE)
    else $error("no stop after last segment");
  a_fetch_len: assert property ( // R4
    (state_r == ST_FETCH && fidx_r == 4'h0 && !cmd)
    |-> ##7 (state_r == ST_FETCH) ##1 (state_r == ST_RUN || cmd))
    else $error("entry fetch not eight bytes");
  a_tick_ms: assert property ( // R8
    (cmd && ctrl_r == 8'hdb) |=> ms_r)
    else $error("millisecond base not selected");

  c_profile_done: cover property (done_ev && segn_r > 8'h01);
  c_pwm_running:  cover property (state_r == ST_PWM && out_r);
  c_neg_delta:    cover property (state_r == ST_RUN && delta_r[15]);
endmodule : pulse_gen

/* File: tb/step_drive_model.sv */
`timescale 1ns/1ps
// Step drive: counts steps, times each one
module step_drive_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Step input
  input wire logic pulse_output_pin
);
  int   cyc;            // Cycle count
  int   n_pulse;        // Steps seen
  int   rise_at[0:399]; // Cycle of each rising edge
  int   high_len[0:399];// High time of each step
  logic pin_d;          // Last pin level
  // Sampled on the clock so edges land on whole cycles
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cyc <= 0;
      n_pulse <= 0;
      pin_d <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      pin_d <= pulse_output_pin;
      // Rising edge starts a step
      if (pulse_output_pin && !pin_d && n_pulse < 400)
      begin
        rise_at[n_pulse] <= cyc;
        n_pulse <= n_pulse + 1;
      end
      // Falling edge closes its width
      if (!pulse_output_pin && pin_d && n_pulse > 0)
        high_len[n_pulse-1] <= cyc - rise_at[n_pulse-1];
    end
  end
endmodule : step_drive_model

/* File: tb/profiled_pulse_train_and_pwm_bench.sv */
`timescale 1ns/1ps
module profiled_pulse_train_and_pwm_bench;
  import pulse_gen_pkg::*;
  localparam int MS = 100;   // Short ms tick keeps the run brief
  logic        clock;        // System clock
  logic        rst;          // Reset
  bus_req_type req;          // Register request
  logic [31:0] rdata;        // Read data
  logic        pin;          // Pulse output
  logic        irq;          // Interrupt
  int          n_mismatch;   // Mismatches
  int          check_count;  // Comparisons
  logic [31:0] got;          // Last read
  int          b;            // First step index of a run

  pulse_gen #(.TICK_MS_CYCLES(MS)) dut (.clock(clock), .rst(rst), .bus_req(req),
    .rdata(rdata), .pulse_output_pin(pin), .irq(irq));
  step_drive_model drive (.clock(clock), .rst(rst), .pulse_output_pin(pin));

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr

  // One-cycle read; data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd

  // Table byte at the write pointer
  task automatic put(input logic [7:0] v);
    wr(8'h14, {24'h0, v});
  endtask : put

  // Entry, most significant byte first
  task automatic seg(input logic [15:0] p, input logic [15:0] d, input logic [31:0] c);
    logic [63:0] e;
    e = {p, d, c};
    for (int i = 7; i >= 0; i--)
      put(e[i*8 +: 8]);
  endtask : seg

  // Poll the idle bit, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    got = 32'h0;
    while (got[0] !== 1'b1 && n < 20000)
    begin
      rd(8'h1c);
      n++;
    end
    // A generator that never goes idle is a failure, not a silent pass
    if (got[0] !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR at %0t: idle wait timed out", $time);
    end
  endtask : wait_idle

  // Judge the last whole PWM cycle after a fresh start
  task automatic pwm_chk(input int per, input int hi, input string m);
    int i;
    int n0;
    n0 = drive.n_pulse;
    repeat (3 * per + 10) @(posedge clock);
    i = drive.n_pulse;
    // Stale steps from an earlier run must not be judged
    chk(32'(i - n0 >= 3), 32'h1, m);
    chk(32'(drive.rise_at[i-1] - drive.rise_at[i-2]), 32'(per), m);
    chk(32'(drive.high_len[i-2]), 32'(hi), m);
  endtask : pwm_chk

  task automatic t_reset();
    chk(pin, 1'b0, "pin after reset");
    rd(8'h1c);
    chk(got[0], 1'b1, "idle after reset");
    rd(8'h2c);
    chk(got, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pwm();
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'hd3);
    repeat (300) @(posedge clock);
    chk(32'(drive.n_pulse), 32'h0, "output before command");
    wr(8'h18, 32'h0);
    rd(8'h1c);
    chk(got[1:0], 32'h2, "pwm status");
    pwm_chk(200, 50, "us pwm");
    wr(8'h08, 32'h3);
    pwm_chk(200, 50, "width write alone");
    wr(8'h00, 32'hd2);
    wr(8'h04, 32'h8);
    wr(8'h08, 32'h2);
    wr(8'h18, 32'h0);
    pwm_chk(200, 100, "width only reload");
    wr(8'h00, 32'hdb);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h1);
    wr(8'h18, 32'h0);
    pwm_chk(4 * MS, MS, "ms pwm");
    // Period word changed too, but only the width may be taken
    wr(8'h00, 32'hda);
    wr(8'h04, 32'h8);
    wr(8'h08, 32'h3);
    wr(8'h18, 32'h0);
    pwm_chk(4 * MS, 3 * MS, "ms width reload");
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h0);
    repeat (4) @(posedge clock);
    chk(pin, 1'b0, "disabled");
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_prof();
    int hi[5];
    int d;
    hi = '{100, 150, 200, 150, 100};
    wr(8'h28, 32'h1);
    wr(8'h0c, 32'h700);
    wr(8'h10, 32'h700);
    put(8'h02);
    seg(16'h4, 16'h2, 32'h3);
    seg(16'h6, 16'hffff, 32'h2);
    b = drive.n_pulse;
    wr(8'h00, 32'ha0);
    wr(8'h18, 32'h0);
    rd(8'h1c);
    chk(got[15:8], 32'h1, "segment number");
    wait_idle();
    chk(got[0], 1'b1, "idle at end");
    chk(32'(drive.n_pulse - b), 32'h5, "step total");
    for (int i = 0; i < 5; i++)
      chk(32'(drive.high_len[b+i]), 32'(hi[i]), "step width");
    chk(32'(drive.rise_at[b+1] - drive.rise_at[b]), 32'd200, "first period");
    chk(32'(drive.rise_at[b+2] - drive.rise_at[b+1]), 32'd300, "stepped period");
    d = drive.rise_at[b+3] - drive.rise_at[b];
    chk(32'(d >= 900 && d <= 910), 32'h1, "segment duration");
    chk(irq, 1'b1, "irq on completion");
    wr(8'h24, 32'h1);
    rd(8'h20);
    chk(got, 32'h0, "flag cleared");
    chk(irq, 1'b0, "irq cleared");
    $display("test profile done");
  endtask : t_prof

  task automatic t_empty();
    wr(8'h28, 32'h0);
    wr(8'h0c, 32'h7f0);
    wr(8'h10, 32'h7f0);
    put(8'h00);
    wr(8'h00, 32'ha0);
    wr(8'h18, 32'h0);
    wait_idle();
    rd(8'h20);
    chk(got, 32'h1, "empty profile event");
    chk(irq, 1'b0, "masked irq");
    wr(8'h28, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1, "unmasked irq");
    wr(8'h24, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "irq cleared");
    $display("test empty done");
  endtask : t_empty

  task automatic t_full();
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h0);
    put(8'hff);
    for (int i = 0; i < 255; i++)
      seg(16'h2, 16'h0, 32'h1);
    b = drive.n_pulse;
    wr(8'h00, 32'ha0);
    wr(8'h18, 32'h0);
    wait_idle();
    chk(32'(drive.n_pulse - b), 32'd255, "full profile steps");
    $display("test full done");
  endtask : t_full

  // Counts, verdict, end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Watchdog, well past the expected run
  initial
  begin
    #1600000;
    n_mismatch++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    got = 32'h0;
    b = 0;
    req = '0;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_pwm();
    t_prof();
    t_empty();
    t_full();
    report_and_stop();
  end
endmodule : profiled_pulse_train_and_pwm_bench
